/* File: rtl/csfs_defines.vh */
// Constants of the charger safety and fault supervisor.
// Assumes one 100 MHz clock and a register port from the serial interface.
`ifndef CSFS_DEFINES_VH
`define CSFS_DEFINES_VH
`define CSFS_CLK_MHZ      100
`define CSFS_RETRY_MS     2000
`define CSFS_RETRY_CYC    (`CSFS_RETRY_MS * 1000 * `CSFS_CLK_MHZ)
`define CSFS_NOPULSE_MS   30
`define CSFS_NOPULSE_CYC  (`CSFS_NOPULSE_MS * 1000 * `CSFS_CLK_MHZ)
`define CSFS_PROBE_MS     250
`define CSFS_PROBE_CYC    (`CSFS_PROBE_MS * 1000 * `CSFS_CLK_MHZ)
`define CSFS_STATPLS_US   128
`define CSFS_STATPLS_CYC  (`CSFS_STATPLS_US * `CSFS_CLK_MHZ)
`define CSFS_RAMP_US      64
`define CSFS_RAMP_CYC     (`CSFS_RAMP_US * `CSFS_CLK_MHZ)
`define CSFS_A_STATUS     3'h0
`define CSFS_A_CONTROL    3'h1
`define CSFS_A_TARGET     3'h2
`define CSFS_A_CURRENT    3'h4
`define CSFS_A_SPECIAL    3'h5
`define CSFS_A_CEILING    3'h6
`define CSFS_RST_CONTROL  8'h30
`define CSFS_RST_TARGET   8'h0A
`define CSFS_RST_CURRENT  8'h09
`define CSFS_RST_SPECIAL  8'h02
`define CSFS_RST_CEILING  8'h40
`define CSFS_B_ENDLOW     3
`define CSFS_B_SPFLAG     4
`define CSFS_VMIN_CODE    6'h23
`define CSFS_FOLD_CODE    3'h0
`define CSFS_F_NONE       3'h0
`define CSFS_F_OVP        3'h1
`define CSFS_F_UV         3'h3
`define CSFS_F_BATOVP     3'h4
`define CSFS_F_HOT        3'h5
`define CSFS_F_NOBAT      3'h7
`define CSFS_P_READY      2'h0
`define CSFS_P_CHARGE     2'h1
`define CSFS_P_DONE       2'h2
`define CSFS_P_FAULT      2'h3
`endif

/* File: rtl/csfs_supervisor.v */
// Supervisory fault and safety logic of the charger.
// Assumes comparator levels from the analog core and a decoded register port.
`timescale 1ns/1ps
`default_nettype none
`include "csfs_defines.vh"
module csfs_supervisor #(
  parameter integer RETRY_CYC   = `CSFS_RETRY_CYC,
  parameter integer NOPULSE_CYC = `CSFS_NOPULSE_CYC,
  parameter integer PROBE_CYC   = `CSFS_PROBE_CYC,
  parameter integer STATPLS_CYC = `CSFS_STATPLS_CYC,
  parameter integer RAMP_CYC    = `CSFS_RAMP_CYC
) (
  input  wire       MCLK,
  input  wire       RESET_N,
  input  wire       REG_WR,
  input  wire       REG_RD,
  input  wire [2:0] REG_ADDR,
  input  wire [7:0] REG_WDATA,
  output reg  [7:0] REG_RDATA,
  input  wire       VBUS_LOW,
  input  wire       VBUS_SLEEP,
  input  wire       VBUS_OVP,
  input  wire       VBUS_OVP_CLR,
  input  wire       VBAT_SHORT,
  input  wire       VBAT_RCH_OK,
  input  wire       VBAT_ABOVE_TGT,
  input  wire       DIE_FOLD,
  input  wire       DIE_HOT,
  input  wire       VBUS_AT_SP,
  input  wire       IN_LIM_HIT,
  input  wire       TERM_DET,
  input  wire       VBUS_VALID,
  input  wire       PWM_PULSE,
  output reg        CHG_EN,
  output reg        INPUT_SW_EN,
  output reg        SLEEP_BLOCK,
  output reg        LINEAR_SRC_EN,
  output reg        PROBE_SINK_EN,
  output reg  [2:0] CUR_CODE,
  output reg  [5:0] VOLT_CODE,
  output reg        STAT_O,
  output reg        STAT_OE
);

  localparam [2:0] S_CHG   = 3'b000;
  localparam [2:0] S_UV    = 3'b001;
  localparam [2:0] S_RETRY = 3'b010;
  localparam [2:0] S_OVP   = 3'b011;
  localparam [2:0] S_BOVP  = 3'b100;
  localparam [2:0] S_PROBE = 3'b101;
  localparam [2:0] S_DONE  = 3'b110;

  // Ceiling on the target voltage code
  function [5:0] clamp_volt;
    input [5:0] req;
    input [3:0] ceil;
    reg   [5:0] top;
    begin
      top        = `CSFS_VMIN_CODE + {2'b00, ceil};
      clamp_volt = (req > top) ? top : req;
    end
  endfunction

  // Ceiling on the charge current code
  function [2:0] clamp_cur;
    input [2:0] req;
    input [2:0] ceil;
    begin
      clamp_cur = (req > ceil) ? ceil : req;
    end
  endfunction

  // Cycle limit reached
  function at_lim;
    input [31:0] cnt;
    input integer lim;
    begin
      at_lim = (cnt >= lim - 1);
    end
  endfunction

  wire [11:0] ain = {VBUS_LOW, VBUS_SLEEP, VBUS_OVP, VBUS_OVP_CLR, VBAT_SHORT, VBAT_RCH_OK,
                     VBAT_ABOVE_TGT, DIE_FOLD, DIE_HOT, VBUS_AT_SP, IN_LIM_HIT, TERM_DET};
  reg  [11:0] s1_q;
  reg  [11:0] s2_q;
  reg  [11:0] s3_q;
  reg  [11:0] flt_q;

  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s1_q  <= 12'h000;
      s2_q  <= 12'h000;
      s3_q  <= 12'h000;
      flt_q <= 12'h000;
    end else begin
      s1_q  <= ain;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      flt_q <= (s2_q & s3_q) | (flt_q & (s2_q | s3_q));
    end
  end

  wire vbus_low  = flt_q[11];
  wire vbus_slp  = flt_q[10];
  wire vbus_ovp  = flt_q[9];
  wire ovp_clr   = flt_q[8];
  wire vbat_shrt = flt_q[7];
  wire rch_ok    = flt_q[6];
  wire above_tgt = flt_q[5];
  wire die_fold  = flt_q[4];
  wire die_hot   = flt_q[3];
  wire at_sp     = flt_q[2];
  wire lim_hit   = flt_q[1];
  wire term_det  = flt_q[0];

  reg  [2:0]  st_q;
  reg  [2:0]  st_d;
  reg  [31:0] tmr_q;
  reg         tmr_clr;
  reg  [2:0]  fault_q;
  reg  [1:0]  phase_q;
  reg  [1:0]  phase_d;
  reg         code_wr;
  reg  [2:0]  code_val;
  reg         pls_go;
  reg         dflt;
  reg  [31:0] pls_q;
  reg         hot_prev_q;
  reg         shrt_prev_q;
  reg  [7:0]  r1_q;
  reg  [7:0]  r2_q;
  reg  [7:0]  r4_q;
  reg  [7:0]  r5_q;
  reg  [7:0]  r6_q;
  reg         safe_open_q;
  reg  [2:0]  ramp_q;
  reg  [31:0] rdiv_q;
  reg         sp_flag_q;

  wire end_low = r1_q[`CSFS_B_ENDLOW];
  wire sleep   = !vbus_low && vbus_slp;
  wire run     = (st_q == S_CHG) && !die_hot && !sleep;

  always @* begin
    st_d     = st_q;
    phase_d  = phase_q;
    tmr_clr  = 1'b0;
    code_wr  = 1'b0;
    code_val = fault_q;
    pls_go   = 1'b0;
    dflt     = 1'b0;
    if (die_hot) begin
      if (!hot_prev_q) begin
        code_wr  = 1'b1;
        code_val = `CSFS_F_HOT;
        pls_go   = 1'b1;
      end
    end else if (vbus_ovp && st_q != S_OVP) begin
      st_d     = S_OVP;
      phase_d  = `CSFS_P_FAULT;
      code_wr  = 1'b1;
      code_val = `CSFS_F_OVP;
      pls_go   = 1'b1;
    end else begin
      case (st_q)
        S_CHG: begin
          if (vbus_low) begin
            st_d     = S_UV;
            phase_d  = `CSFS_P_FAULT;
            code_wr  = 1'b1;
            code_val = `CSFS_F_UV;
            pls_go   = 1'b1;
          end else if (!end_low && above_tgt && at_lim(tmr_q, NOPULSE_CYC)) begin
            st_d     = S_BOVP;
            phase_d  = `CSFS_P_FAULT;
            code_wr  = 1'b1;
            code_val = `CSFS_F_BATOVP;
            pls_go   = 1'b1;
          end else if (end_low && term_det && !sleep) begin
            st_d    = S_PROBE;
            phase_d = `CSFS_P_DONE;
            tmr_clr = 1'b1;
          end else begin
            tmr_clr = PWM_PULSE || !above_tgt;
          end
        end
        S_UV: begin
          if (!vbus_low) begin
            st_d    = S_RETRY;
            tmr_clr = 1'b1;
          end
        end
        S_RETRY: begin
          if (at_lim(tmr_q, RETRY_CYC)) begin
            st_d    = S_CHG;
            phase_d = `CSFS_P_CHARGE;
            tmr_clr = 1'b1;
          end
        end
        S_OVP: begin
          if (ovp_clr && VBUS_VALID) begin
            st_d    = S_CHG;
            phase_d = `CSFS_P_CHARGE;
            tmr_clr = 1'b1;
          end
        end
        S_BOVP: begin
          if (!above_tgt) begin
            st_d    = S_CHG;
            phase_d = `CSFS_P_CHARGE;
            tmr_clr = 1'b1;
          end
        end
        S_PROBE: begin
          if (at_lim(tmr_q, PROBE_CYC)) begin
            tmr_clr = 1'b1;
            code_wr = 1'b1;
            if (rch_ok) begin
              st_d     = S_DONE;
              code_val = `CSFS_F_NONE;
            end else begin
              st_d     = S_RETRY;
              phase_d  = `CSFS_P_FAULT;
              code_val = `CSFS_F_NOBAT;
              pls_go   = 1'b1;
              dflt     = 1'b1;
            end
          end
        end
        S_DONE: begin
          if (!rch_ok) begin
            st_d    = S_CHG;
            phase_d = `CSFS_P_CHARGE;
            tmr_clr = 1'b1;
          end
        end
        default: begin
          st_d    = S_CHG;
          tmr_clr = 1'b1;
        end
      endcase
    end
  end

  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q        <= S_CHG;
      phase_q     <= `CSFS_P_CHARGE;
      fault_q     <= `CSFS_F_NONE;
      tmr_q       <= 32'h0000_0000;
      pls_q       <= 32'h0000_0000;
      hot_prev_q  <= 1'b0;
      shrt_prev_q <= 1'b0;
      STAT_O      <= 1'b0;
      STAT_OE     <= 1'b0;
    end else begin
      st_q        <= st_d;
      phase_q     <= phase_d;
      hot_prev_q  <= die_hot;
      shrt_prev_q <= vbat_shrt;
      STAT_O      <= 1'b0;
      if (tmr_clr) begin
        tmr_q <= 32'h0000_0000;
      end else if (!die_hot) begin
        tmr_q <= tmr_q + 32'h0000_0001;
      end
      if (code_wr) begin
        fault_q <= code_val;
      end
      if (pls_go) begin
        pls_q   <= STATPLS_CYC - 1;
        STAT_OE <= 1'b1;
      end else if (pls_q != 32'h0000_0000) begin
        pls_q <= pls_q - 32'h0000_0001;
      end else begin
        STAT_OE <= 1'b0;
      end
    end
  end

  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r1_q        <= `CSFS_RST_CONTROL;
      r2_q        <= `CSFS_RST_TARGET;
      r4_q        <= `CSFS_RST_CURRENT;
      r5_q        <= `CSFS_RST_SPECIAL;
      r6_q        <= `CSFS_RST_CEILING;
      safe_open_q <= 1'b1;
      REG_RDATA   <= 8'h00;
    end else begin
      if (REG_WR) begin
        case (REG_ADDR)
          `CSFS_A_CONTROL: r1_q <= REG_WDATA;
          `CSFS_A_TARGET:  r2_q <= {clamp_volt(REG_WDATA[7:2], r6_q[3:0]), REG_WDATA[1:0]};
          `CSFS_A_CURRENT: r4_q <= {REG_WDATA[7], clamp_cur(REG_WDATA[6:4], r6_q[6:4]),
                                    REG_WDATA[3:0]};
          `CSFS_A_SPECIAL: r5_q <= {REG_WDATA[7:5], 1'b0, REG_WDATA[3:0]};
          `CSFS_A_CEILING: if (safe_open_q) r6_q <= REG_WDATA;
          default: ;
        endcase
      end
      if (dflt) begin
        r1_q <= `CSFS_RST_CONTROL;
        r2_q <= `CSFS_RST_TARGET;
        r4_q <= `CSFS_RST_CURRENT;
        r5_q <= `CSFS_RST_SPECIAL;
      end
      if (shrt_prev_q && !vbat_shrt) begin
        r6_q        <= `CSFS_RST_CEILING;
        safe_open_q <= 1'b1;
      end else if (vbat_shrt) begin
        safe_open_q <= 1'b1;
      end else if (REG_WR && REG_ADDR != `CSFS_A_CEILING) begin
        safe_open_q <= 1'b0;
      end
      if (REG_RD) begin
        case (REG_ADDR)
          `CSFS_A_STATUS:  REG_RDATA <= {2'b00, phase_q, 1'b0, fault_q};
          `CSFS_A_CONTROL: REG_RDATA <= r1_q;
          `CSFS_A_TARGET:  REG_RDATA <= r2_q;
          `CSFS_A_CURRENT: REG_RDATA <= r4_q;
          `CSFS_A_SPECIAL: REG_RDATA <= {r5_q[7:5], sp_flag_q, r5_q[3:0]};
          `CSFS_A_CEILING: REG_RDATA <= r6_q;
          default:         REG_RDATA <= 8'h00;
        endcase
      end
    end
  end

  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ramp_q        <= 3'h0;
      rdiv_q        <= 32'h0000_0000;
      sp_flag_q     <= 1'b0;
      CHG_EN        <= 1'b0;
      INPUT_SW_EN   <= 1'b0;
      SLEEP_BLOCK   <= 1'b0;
      LINEAR_SRC_EN <= 1'b0;
      PROBE_SINK_EN <= 1'b0;
      CUR_CODE      <= 3'h0;
      VOLT_CODE     <= 6'h00;
    end else begin
      if (st_q != S_CHG) begin
        ramp_q <= 3'h0;
        rdiv_q <= 32'h0000_0000;
      end else if (run) begin
        if (at_lim(rdiv_q, RAMP_CYC)) begin
          rdiv_q <= 32'h0000_0000;
          if (!at_sp && !lim_hit && ramp_q < r4_q[6:4]) begin
            ramp_q <= ramp_q + 3'h1;
          end
        end else begin
          rdiv_q <= rdiv_q + 32'h0000_0001;
        end
        if (ramp_q > r4_q[6:4]) begin
          ramp_q <= r4_q[6:4];
        end
      end
      sp_flag_q     <= run && at_sp;
      CHG_EN        <= run && !vbat_shrt;
      LINEAR_SRC_EN <= run && vbat_shrt;
      INPUT_SW_EN   <= (st_q != S_OVP) && !vbus_ovp;
      SLEEP_BLOCK   <= sleep;
      PROBE_SINK_EN <= (st_q == S_PROBE) && !die_hot;
      CUR_CODE      <= die_fold ? `CSFS_FOLD_CODE : ramp_q;
      VOLT_CODE     <= r2_q[7:2];
    end
  end

endmodule // csfs_supervisor
`default_nettype wire

/* File: sim/csfs_host.sv */
// Host model driving the register port of the supervisor.
// Assumes strobes are sampled on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module csfs_host (
  input  wire logic       MCLK,
  input  wire logic [7:0] REG_RDATA,
  output var  logic       REG_WR,
  output var  logic       REG_RD,
  output var  logic [2:0] REG_ADDR,
  output var  logic [7:0] REG_WDATA
);
  initial begin
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 3'h0;
    REG_WDATA = 8'h00;
  end
  // Single byte write, data scrambled after release
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge MCLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge MCLK);
    REG_WR <= 1'b0;
    REG_WDATA <= ~d;
  endtask
  task wr_safety(input logic [7:0] d);
    wr(3'h6, d);
    wr(3'h6, d);
  endtask
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge MCLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    @(posedge MCLK);
    d = REG_RDATA;
  endtask
endmodule // csfs_host
`default_nettype wire

/* File: sim/csfs_supervisor_properties.sv */
// Port assertions of the supervisor.
// Assumes binding to csfs_supervisor with its pulse and probe counts.
`timescale 1ns/1ps
`default_nettype none
module csfs_supervisor_properties #(
  parameter integer STATPLS_CYC = 16,
  parameter integer PROBE_CYC   = 40
) (
  input wire logic       MCLK,
  input wire logic       RESET_N,
  input wire logic       VBUS_LOW,
  input wire logic       VBUS_SLEEP,
  input wire logic       VBUS_OVP,
  input wire logic       DIE_FOLD,
  input wire logic       DIE_HOT,
  input wire logic       CHG_EN,
  input wire logic       INPUT_SW_EN,
  input wire logic       SLEEP_BLOCK,
  input wire logic       LINEAR_SRC_EN,
  input wire logic       PROBE_SINK_EN,
  input wire logic [2:0] CUR_CODE,
  input wire logic       STAT_O,
  input wire logic       STAT_OE
);
  logic [31:0] pls_q;
  logic [31:0] prb_q;
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pls_q <= 32'h0000_0000;
      prb_q <= 32'h0000_0000;
    end else begin
      pls_q <= STAT_OE ? pls_q + 32'h0000_0001 : 32'h0000_0000;
      prb_q <= PROBE_SINK_EN ? prb_q + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  sequence s_ovp; (VBUS_OVP && !DIE_HOT)[*8]; endsequence
  sequence s_hot; DIE_HOT[*8]; endsequence
  sequence s_cool_hot; (DIE_HOT && !DIE_FOLD)[*8]; endsequence
  sequence s_sleep; (VBUS_SLEEP && !VBUS_LOW && !DIE_HOT)[*8]; endsequence
  sequence s_fold; (DIE_FOLD && !DIE_HOT)[*8]; endsequence
  sequence s_uv; (VBUS_LOW && !DIE_HOT)[*8]; endsequence
  a_stat_drive_low: assert property (STAT_OE |-> !STAT_O)
    else $error("indicator driven high");
  a_stat_pulse_len: assert property ($fell(STAT_OE) |-> pls_q == STATPLS_CYC)
    else $error("indicator pulse length wrong");
  a_ovp_opens_sw: assert property (s_ovp |-> !INPUT_SW_EN && !CHG_EN)
    else $error("overvoltage left switch closed");
  a_hot_stops: assert property (s_hot |-> !CHG_EN)
    else $error("charging while hot");
  a_hot_freeze: assert property (s_cool_hot |-> $stable(CUR_CODE))
    else $error("current code moved while hot");
  a_sleep_block: assert property (s_sleep |-> SLEEP_BLOCK && !CHG_EN)
    else $error("sleep not blocking");
  a_fold_low: assert property (s_fold |-> CUR_CODE == 3'h0)
    else $error("fold back not applied");
  a_uv_stops: assert property (s_uv |-> !CHG_EN)
    else $error("charging on low supply");
  a_linear_excl: assert property (LINEAR_SRC_EN |-> !CHG_EN)
    else $error("linear source with switching");
  a_probe_excl: assert property (PROBE_SINK_EN |-> !CHG_EN && !LINEAR_SRC_EN)
    else $error("probe while charging");
  a_probe_len: assert property ($fell(PROBE_SINK_EN) |-> prb_q == PROBE_CYC)
    else $error("probe length wrong");
endmodule // csfs_supervisor_properties
bind csfs_supervisor csfs_supervisor_properties #(
  .STATPLS_CYC(STATPLS_CYC),
  .PROBE_CYC(PROBE_CYC)
) i_csfs_supervisor_properties (
  .MCLK(MCLK), .RESET_N(RESET_N), .VBUS_LOW(VBUS_LOW),
  .VBUS_SLEEP(VBUS_SLEEP), .VBUS_OVP(VBUS_OVP), .DIE_FOLD(DIE_FOLD),
  .DIE_HOT(DIE_HOT), .CHG_EN(CHG_EN), .INPUT_SW_EN(INPUT_SW_EN),
  .SLEEP_BLOCK(SLEEP_BLOCK), .LINEAR_SRC_EN(LINEAR_SRC_EN),
  .PROBE_SINK_EN(PROBE_SINK_EN), .CUR_CODE(CUR_CODE),
  .STAT_O(STAT_O), .STAT_OE(STAT_OE)
);
`default_nettype wire

/* File: sim/csfs_supervisor_bench.sv */
// Self-checking bench of the supervisor.
// Assumes the host model and shortened timing parameters.
`timescale 1ns/1ps
`default_nettype none
module csfs_supervisor_bench;
  localparam integer RETRY = 200;
  localparam integer PROBE = 40;
  logic mclk, reset_n, reg_wr, reg_rd, pwm_pulse, pwm_on, stat_q;
  logic vbus_low, vbus_sleep, vbus_ovp, vbus_ovp_clr, vbat_short, vbat_rch_ok;
  logic vbat_above_tgt, die_fold, die_hot, vbus_at_sp, term_det, vbus_valid, in_lim_hit;
  logic chg_en, input_sw_en, sleep_block, linear_src_en, probe_sink_en;
  logic stat_o, stat_oe;
  logic [2:0] reg_addr, cur_code;
  logic [5:0] volt_code;
  logic [7:0] reg_wdata, reg_rdata, rdv, ceil, d2, d4;
  logic [7:0] rv [0:7];
  integer errors, check_count, cycles, pulses, i;
  csfs_host i_csfs_host (.MCLK(mclk), .REG_RDATA(reg_rdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata));
  csfs_supervisor #(.RETRY_CYC(RETRY), .NOPULSE_CYC(50), .PROBE_CYC(PROBE),
    .STATPLS_CYC(16), .RAMP_CYC(8)) i_csfs_supervisor (
    .MCLK(mclk), .RESET_N(reset_n), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .VBUS_LOW(vbus_low), .VBUS_SLEEP(vbus_sleep), .VBUS_OVP(vbus_ovp),
    .VBUS_OVP_CLR(vbus_ovp_clr), .VBAT_SHORT(vbat_short),
    .VBAT_RCH_OK(vbat_rch_ok), .VBAT_ABOVE_TGT(vbat_above_tgt),
    .DIE_FOLD(die_fold), .DIE_HOT(die_hot), .VBUS_AT_SP(vbus_at_sp),
    .IN_LIM_HIT(in_lim_hit), .TERM_DET(term_det), .VBUS_VALID(vbus_valid),
    .PWM_PULSE(pwm_pulse), .CHG_EN(chg_en), .INPUT_SW_EN(input_sw_en),
    .SLEEP_BLOCK(sleep_block), .LINEAR_SRC_EN(linear_src_en),
    .PROBE_SINK_EN(probe_sink_en), .CUR_CODE(cur_code),
    .VOLT_CODE(volt_code), .STAT_O(stat_o), .STAT_OE(stat_oe));
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    stat_q <= stat_oe;
    if (stat_oe === 1'b1 && stat_q !== 1'b1) pulses <= pulses + 1;
    pwm_pulse <= pwm_on && ($urandom_range(1) == 1);
    if (cycles == 20000) begin
      errors = errors + 1;
      tally_and_finish;
    end
  end
  function logic [5:0] vexp(input logic [5:0] r, input logic [3:0] c);
    vexp = (r > 6'h23 + {2'b00, c}) ? 6'h23 + {2'b00, c} : r;
  endfunction
  function logic [2:0] iexp(input logic [2:0] r, input logic [2:0] c);
    iexp = (r > c) ? c : r;
  endfunction
  task tally_and_finish;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count = check_count + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task w(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  task rr(input logic [2:0] a);
    i_csfs_host.rd(a, rdv);
  endtask
  task fault(input logic [2:0] code, input logic [1:0] ph, input logic useph,
             input logic [7:0] np);
    rr(3'h0);
    chk({5'h0, rdv[2:0]}, {5'h0, code}, "fault");
    if (useph) chk({6'h0, rdv[5:4]}, {6'h0, ph}, "phase");
    chk(pulses[7:0], np, "pulses");
  endtask
  initial begin
    {mclk, reset_n, vbus_low, vbus_sleep, vbus_ovp, vbat_short, vbat_rch_ok} = 7'h00;
    {vbat_above_tgt, die_fold, die_hot, vbus_at_sp, term_det, stat_q, in_lim_hit} = 7'h00;
    {vbus_ovp_clr, vbus_valid, pwm_on, pwm_pulse} = 4'hE;
    {errors, check_count, cycles, pulses} = 128'h0;
    rv = '{8'h10, 8'h30, 8'h0A, 8'h00, 8'h09, 8'h02, 8'h40, 8'h00};
    void'($urandom(32'hc541));
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    w(10);
    for (i = 0; i < 8; i++) begin
      rr(i[2:0]);
      chk(rdv, rv[i], "reset value");
    end
    for (i = 0; i < 4; i++) begin
      vbat_short <= 1'b1;
      w(8);
      chk({6'h0, linear_src_en, chg_en}, 8'h02, "linear");
      vbat_short <= 1'b0;
      w(8);
      rr(3'h6);
      chk(rdv, 8'h40, "reload");
      ceil = (i == 0) ? 8'h00 : (i == 3) ? 8'h7F : {1'b0, 7'($urandom)};
      i_csfs_host.wr_safety(ceil);
      rr(3'h6);
      chk(rdv, ceil, "ceiling");
      d2 = {6'($urandom), 2'b00};
      d4 = 8'($urandom);
      i_csfs_host.wr(3'h2, d2);
      i_csfs_host.wr(3'h4, d4);
      rr(3'h2);
      chk(rdv, {vexp(d2[7:2], ceil[3:0]), 2'b00}, "volt");
      chk({2'h0, volt_code}, {2'h0, vexp(d2[7:2], ceil[3:0])}, "vpin");
      rr(3'h4);
      chk({5'h0, rdv[6:4]}, {5'h0, iexp(d4[6:4], ceil[6:4])}, "amp");
      i_csfs_host.wr(3'h6, ~ceil);
      rr(3'h6);
      chk(rdv, ceil, "lock");
    end
    i_csfs_host.wr(3'h4, 8'h70);
    vbus_at_sp <= 1'b1;
    w(8);
    d4 = {5'h0, cur_code};
    w(32);
    chk({5'h0, cur_code}, d4, "hold");
    rr(3'h5);
    chk({7'h0, rdv[4]}, 8'h01, "collapse");
    vbus_at_sp <= 1'b0;
    w(72);
    chk({5'h0, cur_code}, 8'h07, "ramp");
    rr(3'h5);
    chk({7'h0, rdv[4]}, 8'h00, "collapse");
    die_fold <= 1'b1;
    w(8);
    chk({5'h0, cur_code}, 8'h00, "fold");
    die_fold <= 1'b0;
    w(8);
    chk({5'h0, cur_code}, 8'h07, "unfold");
    for (i = 0; i < 8; i++) begin
      i_csfs_host.wr(3'h5, i[7:0]);
      rr(3'h5);
      chk({5'h0, rdv[2:0]}, i[7:0], "vsp");
    end
    vbus_sleep <= 1'b1;
    w(10);
    chk({6'h0, sleep_block, chg_en}, 8'h02, "sleep");
    chk(pulses[7:0], 8'h00, "sleep pulse");
    vbus_sleep <= 1'b0;
    vbus_ovp <= 1'b1;
    vbus_ovp_clr <= 1'b0;
    w(10);
    chk({6'h0, input_sw_en, chg_en}, 8'h00, "ovp");
    w(40);
    fault(3'h1, 2'h3, 1'b1, 8'h01);
    vbus_ovp <= 1'b0;
    vbus_ovp_clr <= 1'b1;
    vbus_valid <= 1'b0;
    w(20);
    chk({7'h0, chg_en}, 8'h00, "revalidate");
    vbus_valid <= 1'b1;
    w(20);
    chk({6'h0, input_sw_en, chg_en}, 8'h03, "resume");
    vbus_low <= 1'b1;
    w(30);
    fault(3'h3, 2'h3, 1'b1, 8'h02);
    chk({7'h0, chg_en}, 8'h00, "uv stop");
    vbus_low <= 1'b0;
    in_lim_hit <= 1'b1;
    w(RETRY / 2);
    chk({7'h0, chg_en}, 8'h00, "retry wait");
    w(RETRY);
    chk({7'h0, chg_en}, 8'h01, "retry");
    chk({5'h0, cur_code}, 8'h00, "input limit");
    in_lim_hit <= 1'b0;
    die_hot <= 1'b1;
    w(1);
    die_hot <= 1'b0;
    w(10);
    chk(pulses[7:0], 8'h02, "glitch");
    die_hot <= 1'b1;
    w(10);
    d4 = {5'h0, cur_code};
    w(30);
    fault(3'h5, 2'h0, 1'b0, 8'h03);
    chk({4'h0, cur_code, chg_en}, {3'h0, d4[3:0], 1'b0}, "freeze");
    die_hot <= 1'b0;
    w(10);
    chk({7'h0, chg_en}, 8'h01, "cool");
    pwm_on <= 1'b0;
    vbat_above_tgt <= 1'b1;
    w(35);
    chk(pulses[7:0], 8'h03, "early");
    w(40);
    fault(3'h4, 2'h3, 1'b1, 8'h04);
    vbat_above_tgt <= 1'b0;
    pwm_on <= 1'b1;
    term_det <= 1'b1;
    w(20);
    chk({7'h0, probe_sink_en}, 8'h00, "no end");
    term_det <= 1'b0;
    w(8);
    i_csfs_host.wr(3'h1, 8'h38);
    vbat_rch_ok <= 1'b1;
    w(10);
    term_det <= 1'b1;
    w(10);
    chk({6'h0, probe_sink_en, chg_en}, 8'h02, "probe");
    fault(3'h4, 2'h2, 1'b1, 8'h04);
    term_det <= 1'b0;
    w(PROBE + 10);
    fault(3'h0, 2'h2, 1'b1, 8'h04);
    vbat_rch_ok <= 1'b0;
    w(20);
    term_det <= 1'b1;
    w(10);
    term_det <= 1'b0;
    w(PROBE + 10);
    fault(3'h7, 2'h0, 1'b0, 8'h05);
    rr(3'h1);
    chk(rdv, 8'h30, "defaults");
    chk({7'h0, chg_en}, 8'h00, "absent wait");
    w(RETRY + 20);
    chk({7'h0, chg_en}, 8'h01, "absent retry");
    tally_and_finish;
  end
endmodule // csfs_supervisor_bench
`default_nettype wire
